/* osp_pkg.sv */
// Shared constants and types for the paired one-shot pulse timer
package osp_pkg;

   // ==========================================================
   // Bus geometry
   localparam int OSP_AW = 8;
   localparam int OSP_DW = 16;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OSP_A_CTRL = 8'h00;
   localparam logic [7:0] OSP_A_START = 8'h04;
   localparam logic [7:0] OSP_A_STOP = 8'h08;
   localparam logic [7:0] OSP_A_ENST = 8'h0C;
   localparam logic [7:0] OSP_A_MMODE = 8'h10;
   localparam logic [7:0] OSP_A_SMODE = 8'h14;
   localparam logic [7:0] OSP_A_DLY = 8'h18;
   localparam logic [7:0] OSP_A_WID = 8'h1C;
   localparam logic [7:0] OSP_A_MCNT = 8'h20;
   localparam logic [7:0] OSP_A_SCNT = 8'h24;
   localparam logic [7:0] OSP_A_OLVL = 8'h28;
   localparam logic [7:0] OSP_A_OEN = 8'h2C;
   localparam logic [7:0] OSP_A_OCFG = 8'h30;
   localparam logic [7:0] OSP_A_PAIR = 8'h34;

   // ==========================================================
   // Field positions
   localparam int OSP_B_MST = 0;
   localparam int OSP_B_SLV = 1;
   localparam int OSP_B_ES_LO = 6;
   localparam int OSP_B_ES_HI = 7;
   localparam int OSP_B_OMODE = 0;
   localparam int OSP_B_POL = 1;

   // Edge select codes
   localparam logic [1:0] OSP_ES_FALL = 2'h0;
   localparam logic [1:0] OSP_ES_RISE = 2'h1;
   localparam logic [1:0] OSP_ES_BOTH = 2'h2;

   // ==========================================================
   // Reset values
   localparam logic [15:0] OSP_R_WORD = 16'h0000;
   localparam logic [3:0] OSP_R_PAIR = 4'h4;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      OSP_M_IDLE = 3'b001,
      OSP_M_WAIT = 3'b010,
      OSP_M_CNT = 3'b100
   } osp_mst_t;

   typedef enum logic [1:0] {
      OSP_S_IDLE = 2'b01,
      OSP_S_CNT = 2'b10
   } osp_slv_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } osp_bus_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      logic unit;
      logic [3:0] pair;
      logic [15:0] mmode;
      logic [15:0] smode;
      logic [15:0] dly;
      logic [15:0] wid;
      logic lvl;
      logic oe;
      logic omode;
      logic pol;
      logic men;
      logic sen;
      osp_mst_t ms;
      osp_slv_t ss;
      logic [15:0] mcnt;
      logic [15:0] scnt;
      logic done;
      logic pinmode;
      logic [15:0] rdata;
   } osp_state_t;

endpackage

/* osp_top.sv */
// Paired master/slave one-shot pulse timer with register port
//
// Contract
// - Start bits clear themselves; they never read back as one.
// - Start write sets both enable bits; master waits, counter halted.
// - Master counts on valid trigger edge or software master start write.
// - Both counters read back live at any time.
// - Output level and enable of the slave accept writes while running.
// - Trigger loads delay reload; at zero raise done event and halt.
// - A done event with the slave idle loads width reload into slave counter, counts down.
// - Pulse goes active one count clock after the done event.
// - Slave at zero drives inactive level and stops; repeats per trigger.
// - Stop clears both enables, halts counting, counters hold values.
// - Stop leaves the pulse pin at its present level.
// - With output enable clear, pin shows the written output level bit.
// - Unit enable low initialises everything; level zero, pin in port mode.
// - Master 0 pairs with slave 1..3; master 2 only with slave 3.
// - Edge select 00 falling, 01 rising, 10 both, 11 no edge.
// - Polarity 0 active high, 1 active low.
// - Slave is one-count, started by done event, retriggers ignored.
`timescale 1ns/10ps

module osp_top (
   input wire logic mclk,
   input wire logic arst_n,
   input wire osp_pkg::osp_bus_t bus,
   output logic [15:0] rdata,
   input wire logic trigger_input_pin,
   output logic pulse_out,
   output logic pulse_timer_mode,
   output logic master_done_event
);

   // ==========================================================
   // Helpers

   // Legal master/slave channel pairing in the unit
   function automatic logic pair_ok(input logic [3:0] p);
      logic [1:0] m;
      logic [1:0] s;
      m = p[1:0];
      s = p[3:2];
      pair_ok = ((m == 2'h0) && (s != 2'h0)) || ((m == 2'h2) && (s == 2'h3));
   endfunction

   // Initialised image of the whole block
   function automatic osp_pkg::osp_state_t rst_state();
      osp_pkg::osp_state_t r;
      r = '0;
      r.pair = osp_pkg::OSP_R_PAIR;
      r.mmode = osp_pkg::OSP_R_WORD;
      r.smode = osp_pkg::OSP_R_WORD;
      r.dly = osp_pkg::OSP_R_WORD;
      r.wid = osp_pkg::OSP_R_WORD;
      r.mcnt = osp_pkg::OSP_R_WORD;
      r.scnt = osp_pkg::OSP_R_WORD;
      r.rdata = osp_pkg::OSP_R_WORD;
      r.ms = osp_pkg::OSP_M_IDLE;
      r.ss = osp_pkg::OSP_S_IDLE;
      rst_state = r;
   endfunction

   // ==========================================================
   // State

   osp_pkg::osp_state_t st_q;
   osp_pkg::osp_state_t st_d;
   logic trig_fire;
   logic hw_edge;

   // Decoded write strobes and the running flag
   logic w_start;
   logic w_stop;
   logic stop_m;
   logic stop_s;
   logic sw_trig;
   logic running;
   assign w_start = bus.wr && (bus.addr == osp_pkg::OSP_A_START);
   assign w_stop = bus.wr && (bus.addr == osp_pkg::OSP_A_STOP);
   assign stop_m = w_stop && bus.wdata[osp_pkg::OSP_B_MST];
   assign stop_s = w_stop && bus.wdata[osp_pkg::OSP_B_SLV];
   assign sw_trig = w_start && bus.wdata[osp_pkg::OSP_B_MST] && st_q.men;
   assign running = st_q.men || st_q.sen;

   // Edge qualifier on the synchronised trigger; first sync stage unread here
   always_comb begin
      logic rise;
      logic fall;
      rise = st_q.sync2 & ~st_q.sync3;
      fall = ~st_q.sync2 & st_q.sync3;
      unique case (st_q.mmode[osp_pkg::OSP_B_ES_HI:osp_pkg::OSP_B_ES_LO])
         osp_pkg::OSP_ES_FALL: hw_edge = fall;
         osp_pkg::OSP_ES_RISE: hw_edge = rise;
         osp_pkg::OSP_ES_BOTH: hw_edge = rise | fall;
         default: hw_edge = 1'b0; // Prohibited code never triggers
      endcase
   end

   // Only a waiting master may be retriggered; busy master ignores edges
   assign trig_fire = st_q.men && !stop_m && (st_q.ms == osp_pkg::OSP_M_WAIT)
      && (hw_edge || sw_trig);

   // ==========================================================
   // Next-state logic
   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.rdata = osp_pkg::OSP_R_WORD;
      if (!st_q.unit) begin
         // Unit off: every register but the unit bit and the synchroniser held at its initial value
         st_d = rst_state();
         if (bus.wr && (bus.addr == osp_pkg::OSP_A_CTRL)) begin
            st_d.unit = bus.wdata[0];
         end
      end else begin
         // Master channel: delay count after trigger
         if (st_q.men && !stop_m) begin
            unique case (st_q.ms)
               osp_pkg::OSP_M_IDLE: begin
               end
               osp_pkg::OSP_M_WAIT: begin
                  if (trig_fire) begin
                     st_d.mcnt = st_q.dly;
                     st_d.ms = osp_pkg::OSP_M_CNT;
                  end
               end
               osp_pkg::OSP_M_CNT: begin
                  if (st_q.mcnt == 16'h0000) begin
                     st_d.done = 1'b1;
                     st_d.ms = osp_pkg::OSP_M_WAIT;
                  end else begin
                     st_d.mcnt = st_q.mcnt - 16'h0001;
                  end
               end
            endcase
         end
         // Slave channel: one-count pulse width, started by done
         if (st_q.sen && !stop_s) begin
            unique case (st_q.ss)
               osp_pkg::OSP_S_IDLE: begin
                  if (st_q.done) begin
                     st_d.scnt = st_q.wid;
                     st_d.ss = osp_pkg::OSP_S_CNT;
                     if (st_q.oe) begin
                        st_d.lvl = ~st_q.pol;
                     end
                  end
               end
               osp_pkg::OSP_S_CNT: begin
                  // Done during count is dropped, one-count behaviour
                  if (st_q.scnt == 16'h0000) begin
                     st_d.ss = osp_pkg::OSP_S_IDLE;
                     if (st_q.oe) begin
                        st_d.lvl = st_q.pol;
                     end
                  end else begin
                     st_d.scnt = st_q.scnt - 16'h0001;
                  end
               end
            endcase
         end
         // Register writes; stop leaves pin latch untouched
         if (bus.wr) begin
            unique case (bus.addr)
               osp_pkg::OSP_A_CTRL: st_d.unit = bus.wdata[0];
               osp_pkg::OSP_A_START: begin
                  // Slave bit alone is ignored
                  if (bus.wdata[osp_pkg::OSP_B_MST] && !st_q.men) begin
                     st_d.men = 1'b1;
                     st_d.ms = osp_pkg::OSP_M_WAIT;
                     st_d.sen = st_q.sen | bus.wdata[osp_pkg::OSP_B_SLV];
                  end
               end
               osp_pkg::OSP_A_STOP: begin
                  if (stop_m) begin
                     st_d.men = 1'b0;
                     st_d.ms = osp_pkg::OSP_M_IDLE;
                  end
                  if (stop_s) begin
                     st_d.sen = 1'b0;
                     st_d.ss = osp_pkg::OSP_S_IDLE;
                  end
               end
               osp_pkg::OSP_A_MMODE: begin
                  if (running) begin
                     st_d.mmode[osp_pkg::OSP_B_ES_HI:osp_pkg::OSP_B_ES_LO] =
                        bus.wdata[osp_pkg::OSP_B_ES_HI:osp_pkg::OSP_B_ES_LO];
                  end else begin
                     st_d.mmode = bus.wdata;
                  end
               end
               // Locked set-up registers guard the waveform while running
               osp_pkg::OSP_A_SMODE: if (!running) st_d.smode = bus.wdata;
               osp_pkg::OSP_A_DLY: if (!running) st_d.dly = bus.wdata;
               osp_pkg::OSP_A_WID: if (!running) st_d.wid = bus.wdata;
               osp_pkg::OSP_A_OCFG: begin
                  if (!running) begin
                     st_d.omode = bus.wdata[osp_pkg::OSP_B_OMODE];
                     st_d.pol = bus.wdata[osp_pkg::OSP_B_POL];
                  end
               end
               osp_pkg::OSP_A_OLVL: st_d.lvl = bus.wdata[0];
               osp_pkg::OSP_A_OEN: st_d.oe = bus.wdata[0];
               osp_pkg::OSP_A_PAIR: begin
                  if (!running && pair_ok(bus.wdata[3:0])) begin
                     st_d.pair = bus.wdata[3:0];
                  end
               end
               default: begin
               end
            endcase
         end
         // Read mux; start and stop are trigger-only and read zero
         if (bus.rd) begin
            unique case (bus.addr)
               osp_pkg::OSP_A_CTRL: st_d.rdata = {15'h0000, st_q.unit};
               osp_pkg::OSP_A_START: st_d.rdata = 16'h0000;
               osp_pkg::OSP_A_ENST: st_d.rdata = {14'h0000, st_q.sen, st_q.men};
               osp_pkg::OSP_A_MMODE: st_d.rdata = st_q.mmode;
               osp_pkg::OSP_A_SMODE: st_d.rdata = st_q.smode;
               osp_pkg::OSP_A_DLY: st_d.rdata = st_q.dly;
               osp_pkg::OSP_A_WID: st_d.rdata = st_q.wid;
               osp_pkg::OSP_A_MCNT: st_d.rdata = st_q.mcnt;
               osp_pkg::OSP_A_SCNT: st_d.rdata = st_q.scnt;
               osp_pkg::OSP_A_OLVL: st_d.rdata = {15'h0000, st_q.lvl};
               osp_pkg::OSP_A_OEN: st_d.rdata = {15'h0000, st_q.oe};
               osp_pkg::OSP_A_OCFG: st_d.rdata = {14'h0000, st_q.pol, st_q.omode};
               osp_pkg::OSP_A_PAIR: st_d.rdata = {12'h000, st_q.pair};
               default: st_d.rdata = 16'h0000;
            endcase
         end
      end
      // Synchroniser runs regardless of unit state
      st_d.sync1 = trigger_input_pin;
      st_d.sync2 = st_q.sync1;
      st_d.sync3 = st_q.sync2;
      st_d.pinmode = st_d.unit & st_d.omode;
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= rst_state();
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign rdata = st_q.rdata;
   assign pulse_out = st_q.lvl;
   assign pulse_timer_mode = st_q.pinmode;
   assign master_done_event = st_q.done;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_start_reads_zero: assert property (
      st_q.unit && bus.rd && bus.addr == osp_pkg::OSP_A_START |=> rdata == 16'h0000)
      else $error("start register read back nonzero");

   a_start_enables: assert property (
      st_q.unit && w_start && bus.wdata == 16'h0003 && !st_q.men && !w_stop
      |=> st_q.men && st_q.sen && st_q.ms == osp_pkg::OSP_M_WAIT)
      else $error("start write did not enable pair");

   a_wait_halted: assert property (
      st_q.ms == osp_pkg::OSP_M_WAIT && !trig_fire && st_q.unit |=> $stable(st_q.mcnt))
      else $error("master counter moved while waiting");

   a_trigger_loads: assert property (
      trig_fire && st_q.unit
      |=> st_q.ms == osp_pkg::OSP_M_CNT && st_q.mcnt == $past(st_q.dly))
      else $error("trigger did not load delay");

   a_done_at_zero: assert property (
      st_q.unit && st_q.men && !stop_m && st_q.ms == osp_pkg::OSP_M_CNT
      && st_q.mcnt == 16'h0000 |=> master_done_event ##1 !master_done_event)
      else $error("done event missing or too long");

   a_slave_load: assert property (
      st_q.unit && master_done_event && st_q.sen && !stop_s
      && st_q.ss == osp_pkg::OSP_S_IDLE
      |=> st_q.ss == osp_pkg::OSP_S_CNT && st_q.scnt == $past(st_q.wid))
      else $error("slave did not load width");

   a_pulse_active: assert property (
      st_q.unit && master_done_event && st_q.sen && st_q.oe && !stop_s
      && st_q.ss == osp_pkg::OSP_S_IDLE && !(bus.wr && bus.addr == osp_pkg::OSP_A_OLVL)
      |=> pulse_out == ~st_q.pol)
      else $error("pulse not active one clock after done");

   a_pulse_end: assert property (
      st_q.unit && st_q.sen && st_q.oe && !stop_s && st_q.ss == osp_pkg::OSP_S_CNT
      && st_q.scnt == 16'h0000 && !(bus.wr && bus.addr == osp_pkg::OSP_A_OLVL)
      |=> st_q.ss == osp_pkg::OSP_S_IDLE && pulse_out == st_q.pol)
      else $error("pulse did not end at zero");

   a_stop_holds: assert property (
      st_q.unit && w_stop && bus.wdata == 16'h0003
      |=> !st_q.men && !st_q.sen && $stable(st_q.mcnt) && $stable(st_q.scnt)
      && $stable(pulse_out))
      else $error("stop did not freeze pair");

   a_manual_level: assert property (
      st_q.unit && !st_q.oe && bus.wr && bus.addr == osp_pkg::OSP_A_OLVL
      |=> pulse_out == $past(bus.wdata[0]))
      else $error("written level not on pin");

   a_unit_off: assert property (
      !st_q.unit |=> !pulse_out && !pulse_timer_mode && !st_q.men && st_q.mcnt == 16'h0000)
      else $error("unit off did not initialise");

   a_pair_legal: assert property (
      pair_ok(st_q.pair))
      else $error("illegal channel pairing held");

   c_full_pulse: cover property (master_done_event ##1 pulse_out ##[1:20] !pulse_out);
   c_stop_midway: cover property (st_q.ss == osp_pkg::OSP_S_CNT && stop_s);
   c_retrigger: cover property (master_done_event && st_q.ss == osp_pkg::OSP_S_CNT);
   c_sw_trigger: cover property (sw_trig && trig_fire);

endmodule

/* osp_trig_src.sv */
// External trigger source model driving the trigger input pin
`timescale 1ns/10ps

// ==========================================================
// Trigger source
module osp_trig_src (
   input wire logic lvl_req,
   input wire logic slow,
   output logic pin
);
   // Edges land off the clock edge; slow mode lags by several clocks
   always @(lvl_req) begin
      pin <= #(slow ? 37 : 3) lvl_req;
   end

   // Pin idles low until the first requested edge
   initial begin
      pin = 1'b0;
   end
endmodule

/* one_shot_pulse_pair_run_stop_bench.sv */
// Self-checking testbench for the paired one-shot pulse timer
`timescale 1ns/10ps

// ==========================================================
// Bench top
module one_shot_pulse_pair_run_stop_bench;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   osp_pkg::osp_bus_t bus = '0;
   logic [15:0] rdata;
   logic trig_req = 1'b0;
   logic trig_slow = 1'b0;
   logic trigger_input_pin;
   logic pulse_out;
   logic pulse_timer_mode;
   logic master_done_event;
   int fail_count = 0;
   int compares = 0;
   int done_cnt = 0;
   logic [15:0] s1;
   int n;
   int exp_done[4] = '{1, 1, 2, 0};

   osp_top osp_top_i (
      .mclk(mclk),
      .arst_n(arst_n),
      .bus(bus),
      .rdata(rdata),
      .trigger_input_pin(trigger_input_pin),
      .pulse_out(pulse_out),
      .pulse_timer_mode(pulse_timer_mode),
      .master_done_event(master_done_event)
   );

   osp_trig_src osp_trig_src_i (
      .lvl_req(trig_req),
      .slow(trig_slow),
      .pin(trigger_input_pin)
   );

   // 125 MHz clock
   always #4 mclk = ~mclk;

   // Count done pulses on the falling edge, clear of the launch edge
   always @(negedge mclk) begin
      if (master_done_event === 1'b1) begin
         done_cnt++;
      end
   end

   // ==========================================================
   // Tasks
   task automatic end_of_test();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // Bounded wait for the done pulse; a hang ends the run
   task automatic wait_done();
      int i;
      i = 0;
      do begin
         @(posedge mclk);
         #1;
         i++;
      end while (master_done_event !== 1'b1 && i < 200);
      if (i >= 200) begin
         fail_count++;
         $display("[FAIL] t=%0t done pulse never came", $time);
         end_of_test();
      end
   endtask

   // Done, then active one clock later for width plus one clocks
   task automatic pulse_chk(input logic act, input int w);
      int i;
      wait_done();
      chk(16'(pulse_out), {15'h0000, ~act});
      @(posedge mclk);
      #1;
      chk(16'(master_done_event), 16'h0000);
      chk(16'(pulse_out), 16'(act));
      i = 0;
      while (pulse_out === act && i < 200) begin
         i++;
         @(posedge mclk);
         #1;
      end
      chk(16'(i), 16'(w + 1));
      // A pulse that never ends is a hang, so close the run here
      if (i >= 200) begin
         end_of_test();
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      cyc(2);
      arst_n <= 1'b1;
      #1;
      chk({14'h0000, pulse_out, pulse_timer_mode}, 16'h0000);
      rdc(osp_pkg::OSP_A_DLY, 16'h0000);
      $display("test reset done");

      // Set up a delay of 2 and a width of 1, rising edge
      wr(osp_pkg::OSP_A_CTRL, 16'h0001);
      wr(osp_pkg::OSP_A_OCFG, 16'h0001);
      wr(osp_pkg::OSP_A_OEN, 16'h0001);
      wr(osp_pkg::OSP_A_DLY, 16'h0002);
      wr(osp_pkg::OSP_A_WID, 16'h0001);
      wr(osp_pkg::OSP_A_MMODE, 16'h0040);
      wr(osp_pkg::OSP_A_START, 16'h0003);
      chk(16'(pulse_timer_mode), 16'h0001);
      rdc(osp_pkg::OSP_A_START, 16'h0000);
      rdc(osp_pkg::OSP_A_ENST, 16'h0003);
      cyc(5);
      rdc(osp_pkg::OSP_A_MCNT, 16'h0000);
      @(posedge mclk);
      trig_req <= 1'b1;
      pulse_chk(1'b1, 1);
      rdc(osp_pkg::OSP_A_MCNT, 16'h0000);
      wr(osp_pkg::OSP_A_START, 16'h0001);
      pulse_chk(1'b1, 1);
      wr(osp_pkg::OSP_A_DLY, 16'h0005);
      rdc(osp_pkg::OSP_A_DLY, 16'h0002);
      wr(osp_pkg::OSP_A_OEN, 16'h0000);
      rdc(osp_pkg::OSP_A_OEN, 16'h0000);
      wr(osp_pkg::OSP_A_OEN, 16'h0001);
      rdc(osp_pkg::OSP_A_OEN, 16'h0001);
      $display("test start and trigger done");

      // Every edge code while running: one rise then one fall each
      trig_req <= 1'b0;
      cyc(25);
      for (int es = 0; es < 4; es++) begin
         wr(osp_pkg::OSP_A_MMODE, 16'(es << 6));
         n = done_cnt;
         trig_slow <= 1'(es);
         @(posedge mclk);
         trig_req <= 1'b1;
         cyc(25);
         trig_req <= 1'b0;
         cyc(25);
         chk(16'(done_cnt - n), 16'(exp_done[es]));
      end
      trig_slow <= 1'b0;
      $display("test edge select done");

      // Stop, drive a port level, then rerun active low
      wr(osp_pkg::OSP_A_MMODE, 16'h0040);
      wr(osp_pkg::OSP_A_STOP, 16'h0003);
      rdc(osp_pkg::OSP_A_ENST, 16'h0000);
      wr(osp_pkg::OSP_A_OEN, 16'h0000);
      wr(osp_pkg::OSP_A_OLVL, 16'h0001);
      cyc(2);
      #1;
      chk(16'(pulse_out), 16'h0001);
      wr(osp_pkg::OSP_A_OCFG, 16'h0003);
      wr(osp_pkg::OSP_A_OEN, 16'h0001);
      wr(osp_pkg::OSP_A_START, 16'h0003);
      @(posedge mclk);
      trig_req <= 1'b1;
      pulse_chk(1'b0, 1);
      trig_req <= 1'b0;
      $display("test polarity done");

      // Long pulse stopped in mid-count
      wr(osp_pkg::OSP_A_STOP, 16'h0003);
      wr(osp_pkg::OSP_A_OEN, 16'h0000);
      wr(osp_pkg::OSP_A_OLVL, 16'h0000);
      wr(osp_pkg::OSP_A_OCFG, 16'h0001);
      wr(osp_pkg::OSP_A_WID, 16'h0014);
      wr(osp_pkg::OSP_A_OEN, 16'h0001);
      wr(osp_pkg::OSP_A_START, 16'h0003);
      @(posedge mclk);
      trig_req <= 1'b1;
      wait_done();
      cyc(3);
      // Second done lands mid-pulse; slave must keep counting, not reload
      wr(osp_pkg::OSP_A_START, 16'h0001);
      wait_done();
      rdc(osp_pkg::OSP_A_SCNT, 16'h000C);
      rd(osp_pkg::OSP_A_SCNT, s1);
      rdc(osp_pkg::OSP_A_SCNT, s1 - 16'h0002);
      wr(osp_pkg::OSP_A_STOP, 16'h0003);
      rdc(osp_pkg::OSP_A_ENST, 16'h0000);
      chk(16'(pulse_out), 16'h0001);
      rd(osp_pkg::OSP_A_SCNT, s1);
      cyc(4);
      rdc(osp_pkg::OSP_A_SCNT, s1);
      chk(16'(pulse_out), 16'h0001);
      $display("test stop done");

      // Shutdown of the unit initialises everything
      wr(osp_pkg::OSP_A_OLVL, 16'h0000);
      wr(osp_pkg::OSP_A_CTRL, 16'h0000);
      cyc(2);
      #1;
      chk({14'h0000, pulse_out, pulse_timer_mode}, 16'h0000);
      wr(osp_pkg::OSP_A_CTRL, 16'h0001);
      rdc(osp_pkg::OSP_A_WID, 16'h0000);
      rdc(osp_pkg::OSP_A_OLVL, 16'h0000);
      wr(osp_pkg::OSP_A_START, 16'h0002);
      rdc(osp_pkg::OSP_A_ENST, 16'h0000);
      rdc(osp_pkg::OSP_A_PAIR, 16'h0004);
      wr(osp_pkg::OSP_A_PAIR, 16'h0006);
      rdc(osp_pkg::OSP_A_PAIR, 16'h0004);
      wr(osp_pkg::OSP_A_PAIR, 16'h000C);
      rdc(osp_pkg::OSP_A_PAIR, 16'h000C);
      $display("test shutdown done");
      end_of_test();
   end
endmodule
